// ==== dv/sfc_feature_ctrl_tb.sv ====
// testbench for the feature-control block
`timescale 1ns/1ns
module sfc_feature_ctrl_tb;
   import sfc_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic        wcache_en, reorder_en;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   int          n_fail = 0;
   int          total_checks = 0;
   always #5 pclk = ~pclk;
   sfc_host_model i_host (.pclk, .psel, .penable, .pwrite, .paddr,
                          .pwdata, .prdata, .pready, .pslverr);
   sfc_feature_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
                           .paddr, .pwdata, .prdata, .pready, .pslverr,
                           .wcache_en, .reorder_en);
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      logic to;
      i_host.xfer(w, a, d, r, e, to);
      if (to) begin
         n_fail++;
         $display("MISMATCH %0t bus answer never came", $time);
         conclude();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic ee);
      logic [31:0] r;
      logic        e;
      bus(1'b1, a, d, r, e);
      chk(e, ee);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x, input logic ee);
      logic [31:0] r;
      logic        e;
      bus(1'b0, a, 32'h0, r, e);
      chk(e, ee);
      chk(r & m, x);
   endtask
   // waits for the fill walker, then judges the error flag of the command
   task automatic cmd(input logic [15:0] c, input logic [15:0] s,
                      input logic ee);
      logic [31:0] r;
      logic        e;
      int          n;
      wr(ADDR_VALUE, {16'h0, s}, 1'b0);
      wr(ADDR_CMD, {16'h0001, c}, 1'b0);
      for (n = 0; n < 400; n++) begin
         bus(1'b0, ADDR_STATUS, 32'h0, r, e);
         if (r[ST_BUSY] === 1'b0) break;
      end
      if (r[ST_BUSY] !== 1'b0) begin
         n_fail++;
         $display("MISMATCH %0t command never finished", $time);
         conclude();
      end
      chk(r[ST_BUSY], 1'b0);
      chk(r[ST_DONE], 1'b1);
      chk(r[ST_ERR], ee);
   endtask
   task automatic q_chk(input logic [6:0] i, input logic [7:0] x);
      wr(ADDR_QIDX, {25'h0, i}, 1'b0);
      repeat (2) @(posedge pclk);
      rd(ADDR_QDATA, 32'h0000_00FF, {24'h0, x}, 1'b0);
   endtask
   task automatic pol(input logic [15:0] s, input logic sf, input logic x);
      cmd(FC_WCACHE, s, 1'b0);
      wr(ADDR_SETFEAT, {31'h0, sf}, 1'b0);
      rd(ADDR_IDW85, 32'h0000_0020, {26'h0, x, 5'h0}, 1'b0);
      chk(wcache_en, x);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(reorder_en, 1'b1);
      rd(ADDR_INTERVAL, 32'h0000_FFFF, 32'h1, 1'b0);
      rd(ADDR_LIMITS, 32'hFFFF_FFFF, LIMITS_DEF, 1'b0);
      rd(ADDR_SAMPLE, 32'h0000_FFFF, 32'h1, 1'b0);
      wr(ADDR_SETFEAT, 32'h1, 1'b0);
      rd(ADDR_IDW85, 32'h0000_0020, 32'h20, 1'b0);
   endtask
   task automatic t_wcache;
      pol(WC_FORCE_OFF, 1'b1, 1'b0);
      pol(WC_FORCE_ON, 1'b0, 1'b1);
      pol(WC_BY_SETFEAT, 1'b0, 1'b0);
      pol(WC_BY_SETFEAT, 1'b1, 1'b1);
      cmd(FC_WCACHE, 16'h0004, 1'b1);
      chk(wcache_en, 1'b1);
   endtask
   task automatic t_reorder;
      cmd(FC_REORDER, RO_DISABLE, 1'b0);
      chk(reorder_en, 1'b1);
      rd(ADDR_STATUS, 32'h10, 32'h10, 1'b0);
      cmd(FC_REORDER, RO_ENABLE, 1'b0);
      cmd(FC_REORDER, 16'h0003, 1'b1);
   endtask
   task automatic t_interval;
      wr(ADDR_TEMP, 32'h25, 1'b0);
      wr(ADDR_LIMITS, 32'h5A46_E2D8, 1'b0);
      wr(ADDR_SAMPLE, 32'h0000_0007, 1'b0);
      cmd(FC_INTERVAL, 16'h0005, 1'b0);
      wr(ADDR_TEMP, 32'hE7, 1'b0);
      wr(ADDR_QIDX, 32'h0000_0033, 1'b0);
      cmd(FC_INTERVAL, 16'hFFFF, 1'b0);
      rd(ADDR_INTERVAL, 32'h0000_FFFF, 32'hFFFF, 1'b0);
      rd(ADDR_QIDX, 32'h0000_007F, 32'h0, 1'b0);
      q_chk(7'h00, 8'hE7);
      q_chk(7'h01, TEMP_INVALID);
      q_chk(7'h7F, TEMP_INVALID);
      rd(ADDR_LIMITS, 32'hFFFF_FFFF, 32'h5A46_E2D8, 1'b0);
      rd(ADDR_SAMPLE, 32'h0000_FFFF, 32'h7, 1'b0);
      wr(ADDR_TEMP, 32'h11, 1'b0);
      cmd(FC_INTERVAL, INTERVAL_BAD, 1'b1);
      cmd(16'h0000, 16'h0001, 1'b1);
      cmd(16'h0004, 16'h0001, 1'b1);
      cmd(16'hD000, 16'h0001, 1'b1);
      rd(ADDR_INTERVAL, 32'h0000_FFFF, 32'hFFFF, 1'b0);
      q_chk(7'h00, 8'hE7);
   endtask
   task automatic t_bus;
      rd(8'h2C, 32'hFFFF_FFFF, 32'h0, 1'b1);
      wr(ADDR_STATUS, 32'h0, 1'b1);
      rd(8'h05, 32'hFFFF_FFFF, 32'h0, 1'b1);
      wr(8'h2C, 32'h1, 1'b1);
      wr(ADDR_INTERVAL, 32'h7, 1'b1);
      rd(ADDR_INTERVAL, 32'h0000_FFFF, 32'hFFFF, 1'b0);
   endtask
   // second reset in mid-run, with a forced policy and a long interval set
   task automatic t_rst2;
      cmd(FC_WCACHE, WC_FORCE_OFF, 1'b0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_wcache();
      t_reorder();
      t_interval();
      t_bus();
      t_rst2();
      conclude();
   end
endmodule

// ==== dv/sfc_host_model.sv ====
// host model: apb master that issues feature-control traffic
`timescale 1ns/1ns
module sfc_host_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // a zero interval only goes out when a scenario asks for it
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e, output logic to);
      int n;
      to = 1'b1;
      r  = 32'h0;
      e  = 1'b0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            r  = prdata;
            e  = pslverr;
            to = 1'b0;
            break;
         end
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      // released lines flip so a stale value cannot pass for a live one
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule

// ==== hdl/sfc_feature_ctrl.sv ====
// feature-control state settings: write cache policy, reordering, log interval
// Summary of operation
// - write-cache policy code 1: state 1 by set-features, 2 force on, 3 force off.
// - under forced policy, set-features cache requests complete ok but change nothing.
// - identify word 85 bit 5 shows the true write-cache state.
// - policy resets to state 1.
// - reordering code 2: state 1 enables, 2 disables, default 1.
// - reordering state 2 completes without error, reordering stays on.
// - code 3 sets interval in minutes; 0001h-FFFFh valid, zero invalid.
// - new interval resets queue: index zero, entry 0 current temp, rest 80h.
// - queue reset keeps sampling period and the four temperature limits.
// - interval defaults to one minute.
// - the history queue has 128 locations.
// - temperatures are signed bytes; 80h marks invalid entries.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module sfc_feature_ctrl
   import sfc_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             wcache_en,
   output logic             reorder_en
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH != QUEUE_DEPTH) begin
      $error("queue depth must be 128");
   end

   typedef enum logic [1:0] {SFC_IDLE, SFC_FILL, SFC_DONE} sfc_state_t;

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   wire logic setup = psel && !penable;
   wire logic acc   = psel && penable;
   wire logic wr    = acc && pwrite && pready;
   wire logic rd    = setup && !pwrite;
   wire logic known = (paddr[1:0] == 2'b00) && (paddr <= ADDR_SAMPLE);
   wire logic ro    = (paddr == ADDR_STATUS) || (paddr == ADDR_IDW85)
                   || (paddr == ADDR_INTERVAL) || (paddr == ADDR_QDATA);

   sfc_state_t  st_q;
   logic [15:0] cmd_code_q;
   logic [15:0] value_q;
   logic [15:0] wc_policy_q;
   logic        setfeat_wc_q;
   logic [15:0] interval_q;
   logic [7:0]  temp_q;
   logic [AW-1:0] qidx_q;
   logic [31:0] limits_q;
   logic [15:0] sample_q;
   logic        done_q;
   logic        err_q;
   logic        q_busy;
   logic [7:0]  q_rd;
   logic        q_start;

   ////////////////////////////////////////////////////////////////////////
   // command check
   function automatic logic state_ok(input logic [15:0] code,
                                     input logic [15:0] val);
      unique case (code)
         FC_WCACHE:   state_ok = (val >= WC_BY_SETFEAT)
                              && (val <= WC_FORCE_OFF);
         FC_REORDER:  state_ok = (val == RO_ENABLE) || (val == RO_DISABLE);
         FC_INTERVAL: state_ok = (val != INTERVAL_BAD);
         default:     state_ok = 1'b0;
      endcase
   endfunction

   wire logic go     = wr && (paddr == ADDR_CMD) && pwdata[CMD_GO]
                    && (st_q == SFC_IDLE || st_q == SFC_DONE);
   wire logic cmd_ok = state_ok(pwdata[15:0], value_q);
   assign q_start    = go && cmd_ok && (pwdata[15:0] == FC_INTERVAL);

   // effective cache state: policy overrides the set-features choice
   wire logic wc_eff = (wc_policy_q == WC_FORCE_ON)  ? 1'b1 :
                       (wc_policy_q == WC_FORCE_OFF) ? 1'b0 :
                       setfeat_wc_q;

   ////////////////////////////////////////////////////////////////////////
   // command state and settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q       <= SFC_IDLE;
         cmd_code_q <= 16'h0000;
         done_q     <= 1'b0;
         err_q      <= 1'b0;
      end else begin
         unique case (st_q)
            SFC_IDLE, SFC_DONE: begin
               if (go) begin
                  cmd_code_q <= pwdata[15:0];
                  err_q      <= !cmd_ok;
                  done_q     <= !q_start;
                  st_q       <= q_start ? SFC_FILL : SFC_DONE;
               end
            end
            SFC_FILL: begin
               if (!q_busy && !q_start) begin
                  done_q <= 1'b1;
                  st_q   <= SFC_DONE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wc_policy_q  <= WC_BY_SETFEAT;
         interval_q   <= INTERVAL_DEF;
         value_q      <= 16'h0000;
         setfeat_wc_q <= 1'b0;
         temp_q       <= TEMP_INVALID;
         limits_q     <= LIMITS_DEF;
         sample_q     <= SAMPLE_DEF;
         qidx_q       <= '0;
      end else begin
         if (wr && paddr == ADDR_VALUE) value_q <= pwdata[15:0];
         // always accepted; only takes effect while the policy allows it
         if (wr && paddr == ADDR_SETFEAT) setfeat_wc_q <= pwdata[0];
         if (wr && paddr == ADDR_TEMP) temp_q <= pwdata[7:0];
         if (wr && paddr == ADDR_QIDX) qidx_q <= pwdata[AW-1:0];
         // limits and period live apart from the queue, so refill spares them
         if (wr && paddr == ADDR_LIMITS) limits_q <= pwdata;
         if (wr && paddr == ADDR_SAMPLE) sample_q <= pwdata[15:0];
         if (go && cmd_ok && pwdata[15:0] == FC_WCACHE)
            wc_policy_q <= value_q;
         if (q_start) begin
            interval_q <= value_q;
            qidx_q     <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // queue
   sfc_queue_fill #(.DEPTH(DEPTH)) u_queue (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (q_start),
      .cur_temp (temp_q),
      .rd_idx   (qidx_q),
      .rd_data  (q_rd),
      .busy     (q_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // read mux
   wire logic [31:0] status = {27'h0, 1'b1, wc_eff, err_q, done_q,
                               (st_q == SFC_FILL)};
   logic [31:0] rmux;
   always_comb begin
      unique case (paddr)
         ADDR_CMD:      rmux = {16'h0, cmd_code_q};
         ADDR_VALUE:    rmux = {16'h0, value_q};
         ADDR_STATUS:   rmux = status;
         ADDR_SETFEAT:  rmux = {31'h0, setfeat_wc_q};
         ADDR_IDW85:    rmux = 32'(wc_eff) << W85_WCACHE_BIT;
         ADDR_INTERVAL: rmux = {16'h0, interval_q};
         ADDR_TEMP:     rmux = {24'h0, temp_q};
         ADDR_QIDX:     rmux = 32'(qidx_q);
         ADDR_QDATA:    rmux = {24'h0, q_rd};
         ADDR_LIMITS:   rmux = limits_q;
         ADDR_SAMPLE:   rmux = {16'h0, sample_q};
         default:       rmux = 32'h0000_0000;
      endcase
   end

   // no wait state: read data registered at setup, ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         wcache_en  <= 1'b0;
         reorder_en <= 1'b1;
      end else begin
         pready     <= setup;
         pslverr    <= setup && (!known || (pwrite && ro));
         if (rd) prdata <= rmux;
         wcache_en  <= wc_eff;
         // disable request is accepted without error and ignored
         reorder_en <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_policy_default;
      @(posedge pclk) $rose(presetn) |-> wc_policy_q == WC_BY_SETFEAT;
   endproperty
   a_policy_default: assert property (p_policy_default)
      else $error("policy not default after reset");

   property p_force_on;
      @(posedge pclk) disable iff (!presetn)
      wc_policy_q == WC_FORCE_ON |=> wcache_en;
   endproperty
   a_force_on: assert property (p_force_on)
      else $error("forced cache on not honoured");

   property p_force_off;
      @(posedge pclk) disable iff (!presetn)
      (wc_policy_q == WC_FORCE_OFF) [*2] |-> !wcache_en;
   endproperty
   a_force_off: assert property (p_force_off)
      else $error("forced cache off not honoured");

   property p_reorder_on;
      @(posedge pclk) disable iff (!presetn) ##1 reorder_en;
   endproperty
   a_reorder_on: assert property (p_reorder_on)
      else $error("reordering turned off");

   property p_zero_err;
      @(posedge pclk) disable iff (!presetn)
      go && pwdata[15:0] == FC_INTERVAL && value_q == INTERVAL_BAD
      |=> err_q && $stable(interval_q);
   endproperty
   a_zero_err: assert property (p_zero_err)
      else $error("zero interval accepted");

   property p_reserved_err;
      @(posedge pclk) disable iff (!presetn)
      go && pwdata[15:0] > FC_INTERVAL |=> err_q && done_q;
   endproperty
   a_reserved_err: assert property (p_reserved_err)
      else $error("reserved code not rejected");

   property p_fill_done;
      @(posedge pclk) disable iff (!presetn)
      q_start |=> st_q == SFC_FILL ##[128:130] done_q;
   endproperty
   a_fill_done: assert property (p_fill_done)
      else $error("queue fill length wrong");

   property p_keep_limits;
      @(posedge pclk) disable iff (!presetn)
      q_start |=> $stable(limits_q) && $stable(sample_q) && qidx_q == '0;
   endproperty
   a_keep_limits: assert property (p_keep_limits)
      else $error("queue reset disturbed limits");

   property p_follow_setfeat;
      @(posedge pclk) disable iff (!presetn)
      wc_policy_q == WC_BY_SETFEAT |=> wcache_en == $past(setfeat_wc_q);
   endproperty
   a_follow_setfeat: assert property (p_follow_setfeat)
      else $error("cache state does not follow set-features");

   property p_setfeat_ignored;
      @(posedge pclk) disable iff (!presetn)
      wc_policy_q != WC_BY_SETFEAT && $stable(wc_policy_q)
      && $changed(setfeat_wc_q) |-> $stable(wc_eff);
   endproperty
   a_setfeat_ignored: assert property (p_setfeat_ignored)
      else $error("set-features changed a forced cache state");

   property p_idw85_read;
      @(posedge pclk) disable iff (!presetn)
      rd && paddr == ADDR_IDW85 |=> prdata[W85_WCACHE_BIT] == wcache_en;
   endproperty
   a_idw85_read: assert property (p_idw85_read)
      else $error("identify bit differs from cache state");

   property p_interval_default;
      @(posedge pclk) $rose(presetn) |-> interval_q == INTERVAL_DEF;
   endproperty
   a_interval_default: assert property (p_interval_default)
      else $error("interval not default after reset");

   property p_reorder_ok;
      @(posedge pclk) disable iff (!presetn)
      go && pwdata[15:0] == FC_REORDER && value_q == RO_DISABLE
      |=> !err_q && done_q && reorder_en;
   endproperty
   a_reorder_ok: assert property (p_reorder_ok)
      else $error("reorder disable answered with error");

   property p_bad_keeps;
      @(posedge pclk) disable iff (!presetn)
      go && !cmd_ok |=> $stable(wc_policy_q) && $stable(interval_q);
   endproperty
   a_bad_keeps: assert property (p_bad_keeps)
      else $error("rejected command changed a setting");

   property p_interval_set;
      @(posedge pclk) disable iff (!presetn)
      q_start |=> interval_q == $past(value_q) && interval_q != INTERVAL_BAD;
   endproperty
   a_interval_set: assert property (p_interval_set)
      else $error("interval not taken from the command value");

   property p_ro_refused;
      @(posedge pclk) disable iff (!presetn)
      setup && pwrite && ro |=> pready && pslverr;
   endproperty
   a_ro_refused: assert property (p_ro_refused)
      else $error("write to read-only register not refused");
endmodule

// ==== hdl/sfc_pkg.sv ====
// package: register map, feature codes, states and defaults of the feature-control block
package sfc_pkg;
   // apb register byte offsets
   localparam logic [7:0]  ADDR_CMD       = 8'h00;
   localparam logic [7:0]  ADDR_VALUE     = 8'h04;
   localparam logic [7:0]  ADDR_STATUS    = 8'h08;
   localparam logic [7:0]  ADDR_SETFEAT   = 8'h0C;
   localparam logic [7:0]  ADDR_IDW85     = 8'h10;
   localparam logic [7:0]  ADDR_INTERVAL  = 8'h14;
   localparam logic [7:0]  ADDR_TEMP      = 8'h18;
   localparam logic [7:0]  ADDR_QIDX      = 8'h1C;
   localparam logic [7:0]  ADDR_QDATA     = 8'h20;
   localparam logic [7:0]  ADDR_LIMITS    = 8'h24;
   localparam logic [7:0]  ADDR_SAMPLE    = 8'h28;
   // feature codes
   localparam logic [15:0] FC_WCACHE      = 16'h0001;
   localparam logic [15:0] FC_REORDER     = 16'h0002;
   localparam logic [15:0] FC_INTERVAL    = 16'h0003;
   // write-cache policy states
   localparam logic [15:0] WC_BY_SETFEAT  = 16'h0001;
   localparam logic [15:0] WC_FORCE_ON    = 16'h0002;
   localparam logic [15:0] WC_FORCE_OFF   = 16'h0003;
   // reordering states
   localparam logic [15:0] RO_ENABLE      = 16'h0001;
   localparam logic [15:0] RO_DISABLE     = 16'h0002;
   // defaults and markers
   localparam logic [15:0] INTERVAL_DEF   = 16'h0001;
   localparam logic [15:0] INTERVAL_BAD   = 16'h0000;
   localparam logic [7:0]  TEMP_INVALID   = 8'h80;
   localparam int          QUEUE_DEPTH    = 128;
   localparam int          W85_WCACHE_BIT = 5;
   // status bit positions
   localparam int          ST_BUSY        = 0;
   localparam int          ST_DONE        = 1;
   localparam int          ST_ERR         = 2;
   localparam int          ST_WCACHE      = 3;
   localparam int          ST_REORDER     = 4;
   // command register bits, then limit and sampling defaults
   localparam int          CMD_GO         = 16;
   localparam logic [31:0] LIMITS_DEF     = 32'h8080_8080;
   localparam logic [15:0] SAMPLE_DEF     = 16'h0001;
endpackage

// ==== hdl/sfc_queue_fill.sv ====
// temperature history queue with its reset walker
`timescale 1ns/1ns
module sfc_queue_fill
   import sfc_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
)(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     start,
   input  wire logic [7:0]               cur_temp,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic [7:0]                    rd_data,
   output logic                          busy
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("depth must be power of 2");
   end

   logic [7:0]    mem_q [DEPTH];
   logic [AW-1:0] ptr_q;
   logic          busy_q;
   wire  logic    last = (ptr_q == AW'(DEPTH - 1));

   // first location gets current temperature, the rest the invalid mark
   wire  logic [7:0] fill = (ptr_q == '0) ? cur_temp : TEMP_INVALID;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         ptr_q  <= '0;
      end else if (start) begin
         busy_q <= 1'b1;
         ptr_q  <= '0;
      end else if (busy_q) begin
         busy_q <= !last;
         ptr_q  <= ptr_q + AW'(1);
      end
   end

   // no reset on the array: it is walked fully before anything trusts it
   always_ff @(posedge pclk) begin
      if (busy_q) begin
         mem_q[ptr_q] <= fill;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem_q[rd_idx];
      end
   end

   assign busy = busy_q;
endmodule
